//--- core/vga_gen_ctl_defines.vh
`ifndef VGA_GEN_CTL_DEFINES_VH
`define VGA_GEN_CTL_DEFINES_VH
// I/O and memory offsets, equal in both spaces
`define ADDR_STATUS_ONE_MONO  16'h03ba
`define ADDR_STATUS_ONE_COLOR 16'h03da
`define ADDR_STATUS_ZERO      16'h03c2
`define ADDR_FEATURE_RD       16'h03ca
`define ADDR_MISC_RD          16'h03cc
`define ADDR_MISC_WR          16'h03c2
// Pixel pipeline config field positions
`define PIX_RES_MODE_BIT      0
`define PIX_WRAP_BIT          1
`define PIX_OVL_GAMMA_BIT     26
`define PIX_DSP_GAMMA_BIT     27
`define PIX_RESET             32'h00000000
`define PIX_WR_MASK           32'h0c1f9d03
// Misc output and feature control
`define MISC_COLOR_BIT        0
`define MISC_WIN_EN_BIT       1
`define MISC_RESET            8'h00
`define MISC_WR_MASK          8'hef
`define FEAT_RESET            8'h00
`define FEAT_WR_MASK          8'h08
// Status bit positions
`define ST1_RETRACE_BIT       0
`define ST1_VSYNC_BIT         3
`define ST0_CRT_INT_BIT       7
`define ST0_SENSE_BIT         4
// Legacy window
`define WIN_BASE              20'ha0000
`define WIN_END               20'hbffff
`define WRAP_MASK             20'h3ffff
`define CARVE_512K            32'h00080000
`define CARVE_1M              32'h00100000
`endif

//--- core/vga_general_control_decode.v
`include "vga_gen_ctl_defines.vh"
module vga_general_control_decode (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        reset,
	// Host register access
	input  wire        io_req,
	input  wire        mem_req,
	input  wire        wr_en,
	input  wire [15:0] reg_addr,
	input  wire [7:0]  wr_data,
	output reg  [7:0]  rd_data,
	output reg         rd_hit,
	// Pixel pipeline config access
	input  wire        pix_wr,
	input  wire [31:0] pix_wdata,
	output reg  [31:0] pix_rdata,
	// Legacy frame buffer window
	input  wire        win_req,
	input  wire [19:0] win_addr,
	input  wire [31:0] top_of_mem,
	input  wire        carve_1m,
	output reg         win_hit,
	output reg  [31:0] win_phys,
	// Timing from the display engine
	input  wire        h_active,
	input  wire        v_active,
	input  wire        v_sync,
	input  wire        crt_int_pend,
	input  wire        rgb_sense,
	input  wire [1:0]  video_feedback,
	// Control outputs
	output reg         res_mode_hi,
	output reg         dsp_gamma_en,
	output reg         ovl_gamma_en,
	output reg  [7:0]  misc_out,
	output reg  [7:0]  feature_out
);

	reg  [31:0] pix_cfg_r;
	reg  [7:0]  misc_r;
	reg  [7:0]  feat_r;
	reg  [1:0]  ha_s_r;
	reg  [1:0]  va_s_r;
	reg  [1:0]  vs_s_r;
	reg  [1:0]  ci_s_r;
	reg  [1:0]  rs_s_r;
	reg  [3:0]  vf_s_r;
	reg  [7:0]  rd_nxt;
	reg         hit_nxt;
	reg  [19:0] woff;
	wire        acc;
	wire        rd_req;
	wire        wr_req;
	wire [15:0] st1_addr;
	wire        misc_wr;
	wire        feat_wr;
	wire        win_in;
	wire [31:0] carve_size;

	// Exact match of a host offset, no index step involved
	function addr_is;
		input [15:0] addr;
		input [15:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// Inside the legacy frame buffer window
	function in_window;
		input [19:0] addr;
		begin
			in_window = (addr >= `WIN_BASE) && (addr <= `WIN_END);
		end
	endfunction

	// Carve-out size taken from the top of memory
	function [31:0] carve_bytes;
		input one_meg;
		begin
			carve_bytes = one_meg ? `CARVE_1M : `CARVE_512K;
		end
	endfunction

	assign acc        = io_req | mem_req;
	assign rd_req     = acc & ~wr_en;
	assign wr_req     = acc & wr_en;
	assign st1_addr   = misc_r[`MISC_COLOR_BIT] ? `ADDR_STATUS_ONE_COLOR :
		`ADDR_STATUS_ONE_MONO;
	assign misc_wr    = wr_req & addr_is(reg_addr, `ADDR_MISC_WR);
	assign feat_wr    = wr_req & addr_is(reg_addr, st1_addr);
	assign win_in     = in_window(win_addr);
	assign carve_size = carve_bytes(carve_1m);

	// Pin synchronisers
	always @(posedge ref_clk) begin
		if (reset) begin
			ha_s_r <= 2'h0;
			va_s_r <= 2'h0;
			vs_s_r <= 2'h0;
			ci_s_r <= 2'h0;
			rs_s_r <= 2'h0;
			vf_s_r <= 4'h0;
		end else begin
			ha_s_r <= {ha_s_r[0], h_active};
			va_s_r <= {va_s_r[0], v_active};
			vs_s_r <= {vs_s_r[0], v_sync};
			ci_s_r <= {ci_s_r[0], crt_int_pend};
			rs_s_r <= {rs_s_r[0], rgb_sense};
			vf_s_r <= {vf_s_r[1:0], video_feedback};
		end
	end

	// Pixel pipeline config write
	always @(posedge ref_clk) begin
		if (reset)
			pix_cfg_r <= `PIX_RESET;
		else if (pix_wr)
			pix_cfg_r <= pix_wdata & `PIX_WR_MASK;
	end

	// Misc output write
	always @(posedge ref_clk) begin
		if (reset)
			misc_r <= `MISC_RESET;
		else if (misc_wr)
			misc_r <= wr_data & `MISC_WR_MASK;
	end

	// Feature control write, at the emulation-selected address
	always @(posedge ref_clk) begin
		if (reset)
			feat_r <= `FEAT_RESET;
		else if (feat_wr)
			feat_r <= wr_data & `FEAT_WR_MASK;
	end

	// Direct read decode
	always @* begin
		rd_nxt  = 8'h00;
		hit_nxt = 1'b0;
		if (rd_req) begin
			if (addr_is(reg_addr, `ADDR_STATUS_ZERO)) begin
				hit_nxt = 1'b1;
				rd_nxt[`ST0_CRT_INT_BIT] = ci_s_r[1];
				rd_nxt[`ST0_SENSE_BIT] = rs_s_r[1];
			end else if (addr_is(reg_addr, st1_addr)) begin
				hit_nxt = 1'b1;
				rd_nxt[`ST1_RETRACE_BIT] = ~ha_s_r[1] | ~va_s_r[1];
				rd_nxt[`ST1_VSYNC_BIT] = vs_s_r[1];
				rd_nxt[5:4] = vf_s_r[3:2];
			end else if (addr_is(reg_addr, `ADDR_FEATURE_RD)) begin
				hit_nxt = 1'b1;
				rd_nxt = feat_r;
			end else if (addr_is(reg_addr, `ADDR_MISC_RD)) begin
				hit_nxt = 1'b1;
				rd_nxt = misc_r;
			end
		end
	end

	// Window offset with optional wrap
	always @* begin
		woff = win_addr - `WIN_BASE;
		if (!pix_cfg_r[`PIX_WRAP_BIT])
			woff = woff & `WRAP_MASK;
	end

	// Registered read answer
	always @(posedge ref_clk) begin
		if (reset) begin
			rd_data <= 8'h00;
			rd_hit  <= 1'b0;
		end else begin
			rd_data <= rd_nxt;
			rd_hit  <= hit_nxt;
		end
	end

	// Registered window translation
	always @(posedge ref_clk) begin
		if (reset) begin
			win_hit  <= 1'b0;
			win_phys <= 32'h00000000;
		end else begin
			win_hit  <= win_req & misc_r[`MISC_WIN_EN_BIT] & win_in;
			win_phys <= top_of_mem - carve_size + {12'h000, woff};
		end
	end

	// Registered configuration copies
	always @(posedge ref_clk) begin
		if (reset) begin
			pix_rdata    <= 32'h00000000;
			res_mode_hi  <= 1'b0;
			dsp_gamma_en <= 1'b0;
			ovl_gamma_en <= 1'b0;
			misc_out     <= 8'h00;
			feature_out  <= 8'h00;
		end else begin
			pix_rdata    <= pix_cfg_r;
			res_mode_hi  <= pix_cfg_r[`PIX_RES_MODE_BIT];
			dsp_gamma_en <= pix_cfg_r[`PIX_DSP_GAMMA_BIT];
			ovl_gamma_en <= pix_cfg_r[`PIX_OVL_GAMMA_BIT];
			misc_out     <= misc_r;
			feature_out  <= feat_r;
		end
	end

endmodule // vga_general_control_decode

//--- tb/host_bfm.sv
module host_bfm(input wire logic ref_clk,output logic io_req=0,mem_req=0,wr_en=0,
	output logic [15:0] reg_addr=0,output logic [7:0] wr_data=0);
	timeunit 1ns/1ps;
	task acc(input logic m,w,input logic [15:0] a,input logic [7:0] d);
		@(negedge ref_clk) {io_req,mem_req,wr_en,reg_addr,wr_data}={!m,m,w,a,d};
		@(negedge ref_clk) {io_req,mem_req,reg_addr}={2'b0,~a};
	endtask
endmodule // host_bfm

//--- tb/vga_chk.sv
module vga_chk(input wire logic ref_clk,reset,io_req,mem_req,wr_en,rd_hit,res_mode_hi,
	input wire logic h_active,v_active,v_sync,input wire logic [15:0] reg_addr,
	input wire logic [7:0] rd_data,misc_out,feature_out);
	timeunit 1ns/1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire r=(io_req|mem_req)&!wr_en;
	wire [15:0] a=reg_addr;
	chk_misc_read: assert property (r&&a==16'h03cc|=>rd_hit&&rd_data==misc_out)
		else $error("misc");
	chk_feat_read: assert property (r&&a==16'h03ca|=>rd_hit&&rd_data==feature_out)
		else $error("feature");
	chk_unmapped_read: assert property (r&&a==16'h03c4|=>!rd_hit&&rd_data==0)
		else $error("unmapped");
	chk_mono_sel: assert property (r&&a==16'h03da&&!misc_out[0]|=>!rd_hit)
		else $error("mono");
	chk_color_sel: assert property (r&&a==16'h03ba&&misc_out[0]|=>!rd_hit)
		else $error("color");
	chk_active_zero: assert property ((h_active&&v_active)[*4]##0(r&&a==16'h03ba)|=>!rd_data[0])
		else $error("active");
	chk_vsync_bit: assert property (v_sync[*4]##0(r&&a==16'h03da&&misc_out[0])|=>rd_data[3])
		else $error("vsync");
	chk_res_reset: assert property ($past(reset)|->!res_mode_hi)
		else $error("res");
	cover property (r&&a==16'h03cc);
	cover property (rd_hit&&rd_data[3]);
	cover property (r&&a==16'h03c4);
endmodule // vga_chk
bind vga_general_control_decode vga_chk c(.*);

//--- tb/tb.sv
module tb;
	timeunit 1ns/1ps;
	logic ref_clk=0,reset=1,pix_wr=0,win_req=0,carve_1m=0,crt_int_pend,rgb_sense;
	logic h_active=1,v_active=1,v_sync=0;
	logic [1:0] video_feedback;
	logic [19:0] win_addr=20'ha0000;
	logic [31:0] pix_wdata,top_of_mem,rs=26116;
	wire io_req,mem_req,wr_en,rd_hit,win_hit,res_mode_hi,dsp_gamma_en,ovl_gamma_en;
	wire [15:0] reg_addr;
	wire [7:0] wr_data,rd_data,misc_out,feature_out;
	wire [31:0] pix_rdata,win_phys;
	logic [7:0] q[$];
	int mismatches=0,check_count=0,cyc=0;
	always #2 ref_clk=~ref_clk;
	host_bfm h(.*);
	vga_general_control_decode uut(.*);
	function logic [31:0] xs();
		rs^=rs<<13;
		rs^=rs>>17;
		rs^=rs<<5;
		return rs;
	endfunction
	task chk(input string n,input logic [31:0] s,e);
		check_count++;
		if (s!==e) begin
			mismatches++;
			$display("Error %s exp %h got %h",n,e,s);
		end
	endtask
	task rd(input logic m,input logic [15:0] a,input logic [7:0] e);
		q.push_back(e);
		h.acc(m,0,a,0);
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d",check_count,mismatches);
		if (mismatches==0&&check_count>0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge ref_clk) if (rd_hit===1'b1) chk("rd_data",rd_data,q.pop_front());
	always @(posedge ref_clk) if (++cyc>900) begin
		mismatches++;
		print_verdict();
	end
	initial begin
		void'(xs());
		{crt_int_pend,rgb_sense,video_feedback}=rs[3:0];
		top_of_mem=xs();
		pix_wdata=xs();
		repeat (2) @(negedge ref_clk);
		reset=0;
		chk("res_mode_hi",res_mode_hi,0);
		rd(0,16'h03cc,8'h00);
		h.acc(1,1,16'h03c2,8'hfe);
		rd(1,16'h03cc,8'hee);
		h.acc(0,1,16'h03da,8'hff);
		rd(0,16'h03ca,8'h00);
		h.acc(0,1,16'h03ba,8'hff);
		rd(0,16'h03ca,8'h08);
		rd(0,16'h03ba,{2'b0,video_feedback,4'h0});
		h.acc(0,0,16'h03da,0);
		h.acc(1,0,16'h03c4,0);
		h.acc(1,1,16'h03c2,8'hff);
		h.acc(0,0,16'h03ba,0);
		h_active=0;
		repeat (4) @(negedge ref_clk);
		rd(0,16'h03da,{2'b0,video_feedback,4'h1});
		{v_active,v_sync}=2'b01;
		repeat (4) @(negedge ref_clk);
		rd(1,16'h03da,{2'b0,video_feedback,4'h9});
		rd(0,16'h03c2,{crt_int_pend,2'b0,rgb_sense,4'h0});
		$display("register tests done");
		for (int i=0;i<2;i++) begin
			void'(xs());
			{carve_1m,win_req,win_addr}={i[0],1'b1,3'b101,rs[16:0]};
			@(negedge ref_clk) win_req=0;
			chk("win_phys",win_phys,top_of_mem-(32'h80000<<i)+win_addr-32'ha0000);
			chk("win_hit",win_hit,1);
		end
		$display("window tests done");
		pix_wr=1;
		@(negedge ref_clk) pix_wr=0;
		repeat (2) @(negedge ref_clk);
		chk("pix_rdata",pix_rdata,pix_wdata&32'h0c1f9d03);
		chk("res_mode_hi",res_mode_hi,pix_wdata[0]);
		chk("gamma",{dsp_gamma_en,ovl_gamma_en},pix_wdata[27:26]);
		chk("misc_out",misc_out,8'hef);
		chk("feature_out",feature_out,8'h08);
		chk("queue",q.size(),0);
		$display("pixel tests done");
		print_verdict();
	end
endmodule // tb
